/* hdl/vfd_ctrl_pkg.sv */
// What this block does
// [RULE1] Duty first byte: opcode 1010, duty bits 0-1
// [RULE2] Duty second byte holds duty bits 2-9
// [RULE3] Grid on-time duty/1024, capped at 960
// [RULE4] Reset clears duty register to zero
// [RULE5] Host sets duty before display on
// [RULE6] Digit command: opcode 0110, 4-bit count
// [RULE7] Count n scans grids 1..n, zero scans 16
// [RULE8] Reset clears digit count, all 16 scanned
// [RULE9] Host sets digit count before display on
// [RULE10] Lights command 1110: bit0 off, bit1 on
// [RULE11] Force-on beats force-off; neither shows content
// [RULE12] Reset: outputs low, force-off mode set
// [RULE13] Opcode 1111 enters standby, grids low, halted
// [RULE14] Reset during standby leaves it, reinitialises
// [RULE15] Chip select falling wakes from standby
// [RULE16] Host waits settle, then reraises chip select
// [RULE17] Host gives no shift clock before settle
// [RULE18] After standby force-off stays set
// [RULE19] Bytes LSB first on shift clock rising edge
// [RULE20] Bytes counted from chip select falling edge
// [RULE21] Grid slot is 1024 steps, duty steps high
// [RULE22] Duty committed only after second byte
package vfd_ctrl_pkg;

  // Clock and wake-up timing
  localparam int CLK_PERIOD_NS      = 20;
  localparam int OSC_SETTLE_TIME_NS = 10000;
  localparam int OSC_SETTLE_CYCLES  =
    (OSC_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_CYCLES_DEF    = 4;

  // Command opcodes in bits 4 to 7
  localparam int       OPC_LSB    = 4;
  localparam logic [3:0] OP_DUTY    = 4'ha;
  localparam logic [3:0] OP_DIGITS  = 4'h6;
  localparam logic [3:0] OP_LIGHTS  = 4'he;
  localparam logic [3:0] OP_STANDBY = 4'hf;
  localparam logic [3:0] OP_DC_A    = 4'h8;
  localparam logic [3:0] OP_CG_A    = 4'h4;
  localparam logic [3:0] OP_AD_A    = 4'hc;
  localparam logic [3:0] OP_DC_B    = 4'h9;
  localparam logic [3:0] OP_CG_B    = 4'h5;
  localparam logic [3:0] OP_AD_B    = 4'hd;

  // Field positions
  localparam int LIGHT_OFF_BIT = 0;
  localparam int LIGHT_ON_BIT  = 1;

  // Widths and limits
  localparam int         BYTE_W    = 8;
  localparam int         DUTY_W    = 10;
  localparam int         DIGIT_W   = 4;
  localparam int         GRID_N    = 16;
  localparam logic [9:0] DUTY_MAX  = 10'h3c0;
  localparam logic [9:0] STEP_LAST = 10'h3ff;
  localparam logic [2:0] BIT_LAST  = 3'h7;

  // Reset values
  localparam logic [9:0] DUTY_RST      = 10'h000;
  localparam logic [3:0] DIGITS_RST    = 4'h0;
  localparam logic       FORCE_OFF_RST = 1'b1;
  localparam logic       FORCE_ON_RST  = 1'b0;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_RUN     = 2'b00,
    MODE_STANDBY = 2'b01,
    MODE_SETTLE  = 2'b10
  } mode_t;

endpackage

/* hdl/vfd_display_control_commands.sv */
`timescale 1ns/10ps

module vfd_display_control_commands
  import vfd_ctrl_pkg::*;
#(
  parameter int ANODE_W       = 72,
  parameter int STEP_CYCLES   = STEP_CYCLES_DEF,
  parameter int SETTLE_CYCLES = OSC_SETTLE_CYCLES
) (
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire logic               cs_n_in,
  input  wire logic               shift_clock_n_in,
  input  wire logic               serial_data_in,
  input  wire logic [ANODE_W-1:0] anode_content_in,
  output logic      [GRID_N-1:0]  grid_output_out,
  output logic      [ANODE_W-1:0] anode_output_out,
  output logic      [DIGIT_W-1:0] digit_index_out,
  output logic      [BYTE_W-1:0]  rx_byte_out,
  output logic                    rx_strobe_out,
  output logic                    osc_enable_out
);

  localparam int PRE_W = $clog2(STEP_CYCLES + 1);
  localparam int SET_W = $clog2(SETTLE_CYCLES + 1);

  localparam logic [PRE_W-1:0] PRE_LAST =
    PRE_W'(STEP_CYCLES - 1);
  localparam logic [SET_W-1:0] SET_LAST =
    SET_W'(SETTLE_CYCLES - 1);

  // All state of the block
  typedef struct packed {
    logic [2:0]         cs_sync;
    logic [2:0]         sck_sync;
    logic [1:0]         sd_sync;
    mode_t              mode;
    logic [BYTE_W-1:0]  shift;
    logic [2:0]         bit_cnt;
    logic               duty_pending;
    logic [1:0]         duty_low;
    logic               data_mode;
    logic [DUTY_W-1:0]  duty;
    logic [DIGIT_W-1:0] digits;
    logic               force_off;
    logic               force_on;
    logic [PRE_W-1:0]   pre_cnt;
    logic [DUTY_W-1:0]  step_cnt;
    logic [DIGIT_W-1:0] digit;
    logic [SET_W-1:0]   settle_cnt;
    logic [BYTE_W-1:0]  rx_byte;
    logic               rx_strobe;
    logic [GRID_N-1:0]  grid;
    logic [ANODE_W-1:0] anode;
  } state_t;

  // Idle-high link lines start high to avoid false edges
  localparam state_t RESET_STATE = '{
    cs_sync:   3'h7,
    sck_sync:  3'h7,
    mode:      MODE_RUN,
    duty:      DUTY_RST,
    digits:    DIGITS_RST,
    force_off: FORCE_OFF_RST,
    force_on:  FORCE_ON_RST,
    default:   '0
  };

  state_t st;
  state_t next_st;

  // Next-state logic
  always_comb begin
    logic               cs_fall;
    logic               cs_low;
    logic               sck_rise;
    logic               sd_bit;
    logic [BYTE_W-1:0]  byte_now;
    logic [3:0]         opcode;
    logic [DUTY_W-1:0]  eff_duty;
    logic [DIGIT_W-1:0] last_digit;
    logic [GRID_N-1:0]  one_hot;

    cs_fall    = 1'b0;
    cs_low     = 1'b0;
    sck_rise   = 1'b0;
    sd_bit     = 1'b0;
    byte_now   = '0;
    opcode     = '0;
    eff_duty   = '0;
    last_digit = '0;
    one_hot    = '0;

    next_st = st;

    // Two-flop synchronisers plus edge history
    next_st.cs_sync  = {st.cs_sync[1:0], cs_n_in};
    next_st.sck_sync = {st.sck_sync[1:0], shift_clock_n_in};
    next_st.sd_sync  = {st.sd_sync[0], serial_data_in};
    next_st.rx_strobe = 1'b0;

    // Edges seen on synchronised lines only
    cs_fall  = st.cs_sync[2] & ~st.cs_sync[1];
    cs_low   = ~st.cs_sync[1];
    sck_rise = ~st.sck_sync[2] & st.sck_sync[1]; // [RULE19]
    sd_bit   = st.sd_sync[1];
    byte_now = {sd_bit, st.shift[BYTE_W-1:1]}; // [RULE19]
    opcode   = byte_now[BYTE_W-1:OPC_LSB];

    // Mode control and serial receiver
    unique case (st.mode)
      MODE_STANDBY: begin
        if (cs_fall) begin
          next_st.mode       = MODE_SETTLE; // [RULE15]
          next_st.settle_cnt = '0;
        end
      end

      MODE_SETTLE: begin
        // Link ignored until the oscillator is stable
        if (st.settle_cnt == SET_LAST) begin
          next_st.mode = MODE_RUN;
        end else begin
          next_st.settle_cnt = st.settle_cnt + 1'b1;
        end
        next_st.bit_cnt      = '0;
        next_st.duty_pending = 1'b0;
        next_st.data_mode    = 1'b0;
      end

      MODE_RUN: begin
        if (cs_fall) begin
          // Byte framing restarts at chip select falling
          next_st.bit_cnt      = '0; // [RULE20]
          next_st.duty_pending = 1'b0;
          next_st.data_mode    = 1'b0;
        end else if (cs_low && sck_rise) begin
          next_st.shift   = byte_now; // [RULE19]
          next_st.bit_cnt = st.bit_cnt + 1'b1;
          if (st.bit_cnt == BIT_LAST) begin
            // Full byte loads with no external strobe
            next_st.rx_byte   = byte_now; // [RULE20]
            next_st.rx_strobe = 1'b1;
            if (st.duty_pending) begin
              // Commit all ten bits together
              next_st.duty = {byte_now, st.duty_low}; // [RULE2] [RULE22]
              next_st.duty_pending = 1'b0;
            end else if (st.data_mode) begin
              // RAM data bytes belong to the RAM logic
              next_st.data_mode = 1'b1;
            end else begin
              unique case (opcode)
                OP_DUTY: begin
                  next_st.duty_low     = byte_now[1:0]; // [RULE1]
                  next_st.duty_pending = 1'b1; // [RULE22]
                end
                OP_DIGITS: begin
                  next_st.digits = byte_now[DIGIT_W-1:0]; // [RULE6]
                end
                OP_LIGHTS: begin
                  next_st.force_off = byte_now[LIGHT_OFF_BIT]; // [RULE10]
                  next_st.force_on  = byte_now[LIGHT_ON_BIT]; // [RULE10]
                end
                OP_STANDBY: begin
                  next_st.mode      = MODE_STANDBY; // [RULE13]
                  next_st.force_off = 1'b1; // [RULE18]
                  next_st.force_on  = 1'b0;
                end
                OP_DC_A,
                OP_CG_A,
                OP_AD_A,
                OP_DC_B,
                OP_CG_B,
                OP_AD_B: begin
                  next_st.data_mode = 1'b1;
                end
                default: begin
                  next_st.data_mode = st.data_mode;
                end
              endcase
            end
          end
        end
      end

      default: begin
        next_st.mode = MODE_RUN;
      end
    endcase

    // Duty limited to 960 steps of 1024
    eff_duty = (st.duty >= DUTY_MAX) ? DUTY_MAX : st.duty; // [RULE3]

    // Count zero means all sixteen grids
    last_digit = (st.digits == '0) ? DIGIT_W'(GRID_N - 1)
                                   : st.digits - 1'b1; // [RULE7] [RULE8]

    // Grid slot timing, cleared outside run mode
    if (st.mode == MODE_RUN) begin
      if (st.pre_cnt == PRE_LAST) begin
        next_st.pre_cnt  = '0;
        next_st.step_cnt = st.step_cnt + 1'b1; // [RULE21]
        if (st.step_cnt == STEP_LAST) begin
          if (st.digit >= last_digit) begin
            next_st.digit = '0; // [RULE7]
          end else begin
            next_st.digit = st.digit + 1'b1;
          end
        end
      end else begin
        next_st.pre_cnt = st.pre_cnt + 1'b1;
      end
    end else begin
      // Halted scan restarts from the first grid
      next_st.pre_cnt  = '0;
      next_st.step_cnt = '0;
      next_st.digit    = '0; // [RULE13]
    end

    // Selected grid high for duty steps of its slot
    one_hot = {{(GRID_N-1){1'b0}}, 1'b1} << st.digit;
    if (st.mode == MODE_RUN && st.step_cnt < eff_duty) begin
      next_st.grid = one_hot; // [RULE3] [RULE21]
    end else begin
      next_st.grid = '0; // [RULE13]
    end

    // Anode override, force-on has priority
    if (st.mode != MODE_RUN) begin
      next_st.anode = '0; // [RULE13]
    end else if (st.force_on) begin
      next_st.anode = '1; // [RULE11]
    end else if (st.force_off) begin
      next_st.anode = '0; // [RULE11] [RULE18]
    end else begin
      next_st.anode = anode_content_in; // [RULE11]
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= RESET_STATE; // [RULE4] [RULE8] [RULE12] [RULE14]
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign grid_output_out  = st.grid;
  assign anode_output_out = st.anode;
  assign digit_index_out  = st.digit;
  assign rx_byte_out      = st.rx_byte;
  assign rx_strobe_out    = st.rx_strobe;
  assign osc_enable_out   = (st.mode != MODE_STANDBY); // [RULE13] [RULE15]

endmodule

/* verification/vfd_host_model.sv */
`timescale 1ns/10ps
module vfd_host_model (
  output logic cs_n_out,
  output logic sck_n_out,
  output logic sdata_out
);
  // Idle link: deselected, clock high
  initial begin
    cs_n_out  = 1'b1;
    sck_n_out = 1'b1;
    sdata_out = 1'b0;
  end
  // One byte at 160 ns per bit, data leaves after use
  task automatic put_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      sck_n_out = 1'b0;
      sdata_out = b[i];
      #80;
      sck_n_out = 1'b1;
      #40;
      sdata_out = ~b[i]; // Stale bit inverted mid high phase
      #40;
    end
  endtask
  task automatic sel(input logic lvl);
    cs_n_out = lvl;
    #80;
  endtask
  // Wake with no clock pulses, then deselect
  task automatic wake(input int ns);
    cs_n_out = 1'b0;
    #(ns);
    cs_n_out = 1'b1;
    #80;
  endtask
endmodule

/* verification/vfd_ctrl_props.sv */
`timescale 1ns/10ps
module vfd_ctrl_props
  import vfd_ctrl_pkg::*;
#(parameter int ANODE_W = 72, parameter int STEP_CYCLES = 4) (
  input wire logic               clk_in,
  input wire logic               rst_in,
  input wire logic               cs_n_in,
  input wire logic [GRID_N-1:0]  grid_output_out,
  input wire logic [ANODE_W-1:0] anode_output_out,
  input wire logic [BYTE_W-1:0]  rx_byte_out,
  input wire logic               rx_strobe_out,
  input wire logic               osc_enable_out
);
  localparam int CAP = 960 * STEP_CYCLES;
  logic [15:0] on_len;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Cycles the grid has been lit so far
  always_ff @(posedge clk_in)
    on_len <= (rst_in || grid_output_out == '0) ? 16'h0 : on_len + 16'h1;
  // Standby seen while chip select falls
  sequence s_wake;
    !osc_enable_out && $fell(cs_n_in);
  endsequence
  AST_RST_QUIET: assert property (
    $fell(rst_in) |-> grid_output_out == '0 && anode_output_out == '0)
    else $error("outputs lit after reset");
  AST_RST_RUN: assert property (
    $fell(rst_in) |-> osc_enable_out && !rx_strobe_out)
    else $error("not running after reset");
  AST_STROBE_PULSE: assert property (
    rx_strobe_out |=> !rx_strobe_out) else $error("strobe too long");
  AST_BYTE_HOLD: assert property (
    $changed(rx_byte_out) |-> rx_strobe_out)
    else $error("byte changed without strobe");
  AST_ONE_GRID: assert property (
    $onehot0(grid_output_out)) else $error("several grids lit");
  AST_STANDBY_DARK: assert property (
    !osc_enable_out |=> grid_output_out == '0 && !rx_strobe_out)
    else $error("activity in standby");
  AST_WAKE: assert property (
    s_wake |-> ##[1:8] osc_enable_out) else $error("no wake");
  AST_ON_CAP: assert property (
    grid_output_out != '0 |-> on_len < 16'(CAP))
    else $error("grid on-time over cap");
endmodule
bind vfd_display_control_commands vfd_ctrl_props #(
  .ANODE_W(ANODE_W), .STEP_CYCLES(STEP_CYCLES)) u_props (
  .clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n_in),
  .grid_output_out(grid_output_out), .anode_output_out(anode_output_out),
  .rx_byte_out(rx_byte_out), .rx_strobe_out(rx_strobe_out),
  .osc_enable_out(osc_enable_out));

/* verification/vfd_display_control_commands_tb_top.sv */
`timescale 1ns/10ps
module vfd_display_control_commands_tb_top;
  import vfd_ctrl_pkg::*;
  logic               clk_in = 1'b0;
  logic               rst_in = 1'b1;
  logic               cs_n, sck_n, sdata, strobe, osc;
  logic [7:0]         pat = 8'h5a;
  logic [71:0]        content, anode;
  logic [7:0]         rx_byte;
  logic [GRID_N-1:0]  grid;
  logic [DIGIT_W-1:0] digit;
  logic [15:0]        lt [4] = '{16'he45a, 16'he100, 16'he2ff, 16'he3ff};
  int                 err_total = 0;
  int                 total_checks = 0;
  int                 cyc = 0;
  int                 n;
  always #10 clk_in = ~clk_in;
  // Normal anode content, one byte pattern repeated
  assign content = {9{pat}};
  vfd_host_model u_host (.cs_n_out(cs_n), .sck_n_out(sck_n), .sdata_out(sdata));
  vfd_display_control_commands #(.STEP_CYCLES(1)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in),
    .cs_n_in(cs_n), .shift_clock_n_in(sck_n), .serial_data_in(sdata),
    .anode_content_in(content), .grid_output_out(grid),
    .anode_output_out(anode), .digit_index_out(digit),
    .rx_byte_out(rx_byte), .rx_strobe_out(strobe), .osc_enable_out(osc));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Compare both ends of the anode bus with a repeated byte
  task automatic chk_anode(input logic [7:0] e);
    check(anode[15:0], {e, e});
    check(anode[71:56], {e, e});
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
    #2;
  endtask
  task automatic rst_pulse;
    rst_in = 1'b1;
    tick(8);
    rst_in = 1'b0;
    tick(3);
  endtask
  // Send a byte, wait for its strobe, compare the copy
  task automatic cmd(input logic [7:0] b);
    int w;
    w = 0;
    fork
      u_host.put_byte(b);
      while (strobe !== 1'b1 && w < 200) begin tick(1); w++; end
    join
    check(16'(w < 200), 16'h1);
    check(16'(rx_byte), 16'(b));
  endtask
  // Length of the next lit run, 0 when none within 2200 cycles
  task automatic on_time(output int len);
    int w;
    len = 0;
    w = 0;
    while (grid !== '0 && w < 1100) begin tick(1); w++; end
    while (grid === '0 && w < 2200) begin tick(1); w++; end
    while (grid !== '0 && len < 1100) begin tick(1); len++; end
  endtask
  task automatic scan_max(output int mx);
    mx = 0;
    repeat (17408) begin tick(1); if (int'(digit) > mx) mx = int'(digit); end
  endtask
  // Cycle ceiling against hangs
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 90000) begin err_total++; report_and_stop(); end
  end
  // Main sequence
  initial begin
    rst_pulse();
    chk_anode(8'h00);
    on_time(n);
    check(16'(n), 16'h0);
    scan_max(n);
    check(16'(n), 16'hf);
    u_host.sel(1'b0);
    cmd(8'ha1);
    on_time(n);
    check(16'(n), 16'h0);
    cmd(8'h01);
    on_time(n);
    check(16'(n), 16'h5);
    cmd(8'ha3);
    cmd(8'hff);
    on_time(n);
    check(16'(n), 16'h3c0);
    cmd(8'h6f);
    tick(1100);
    scan_max(n);
    check(16'(n), 16'he);
    for (int i = 0; i < 4; i++) begin
      cmd(lt[i][15:8]);
      tick(3);
      chk_anode(lt[i][7:0]);
    end
    cmd(8'hf0);
    u_host.sel(1'b1);
    check(16'(osc), 16'h0);
    u_host.wake(OSC_SETTLE_TIME_NS + 400);
    check(16'(osc), 16'h1);
    chk_anode(8'h00);
    pat = 8'ha5;
    u_host.sel(1'b0);
    cmd(8'he0);
    tick(3);
    chk_anode(8'ha5);
    cmd(8'hf0);
    u_host.sel(1'b1);
    rst_pulse();
    check(16'(osc), 16'h1);
    report_and_stop();
  end
endmodule
